// File: rjhb_unit.sv
`timescale 1ns/1ps
`default_nettype none
module rjhb_unit (
  input wire logic clk_sys,
  input wire logic reset,
  input wire rjhb_pkg::rjhb_issue_t issue,
  input wire logic [rjhb_pkg::XLEN-1:0] src_value,
  input wire logic slot_done,
  input wire logic ctrl_writes_pending,
  input wire logic exception_return_issue,
  input wire logic cop_access_enabled,
  input wire logic compressed_isa_present,
  input wire logic full_isa_present,
  output logic busy,
  output rjhb_pkg::rjhb_wb_t link_wb,
  output rjhb_pkg::rjhb_redirect_t redirect,
  output logic hazard_clear_action,
  output logic hazard_snapshot
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  logic base_ok;          // major and minor groups match
  logic link_jump_reg_barrier;
  logic jump_reg_barrier;
  logic link_jump_reg;
  logic jump_reg_plain;
  logic any_jump;         // one of the register jumps
  logic is_barrier;       // barrier flavour
  logic is_link;          // writes the link register
  logic [4:0] link_reg_field;
  logic [4:0] target_reg_field;

  assign link_reg_field = issue.word[rjhb_pkg::LINK_HI:rjhb_pkg::LINK_LO];
  assign target_reg_field = issue.word[rjhb_pkg::TGT_HI:rjhb_pkg::TGT_LO];
  // no mode or coprocessor check: barrier jumps never fault on privilege
  assign base_ok = issue.valid
    && issue.word[rjhb_pkg::OP_HI:rjhb_pkg::OP_LO] == rjhb_pkg::MAJOR_OPCODE_GROUP
    && issue.word[rjhb_pkg::MIN_HI:rjhb_pkg::MIN_LO] == rjhb_pkg::EXTENDED_MINOR_GROUP;
  assign link_jump_reg_barrier = base_ok
    && issue.word[rjhb_pkg::EXT_HI:rjhb_pkg::EXT_LO] == rjhb_pkg::EXT_BARRIER_JUMP
    && link_reg_field != rjhb_pkg::REG_ZERO;
  assign jump_reg_barrier = base_ok
    && issue.word[rjhb_pkg::EXT_HI:rjhb_pkg::EXT_LO] == rjhb_pkg::EXT_BARRIER_JUMP
    && link_reg_field == rjhb_pkg::REG_ZERO;
  assign link_jump_reg = base_ok
    && issue.word[rjhb_pkg::EXT_HI:rjhb_pkg::EXT8_HI+1] == 2'h0
    && issue.word[rjhb_pkg::EXT8_HI:rjhb_pkg::EXT_LO] == rjhb_pkg::EXT_LINK_JUMP
    && link_reg_field != rjhb_pkg::REG_ZERO;
  assign jump_reg_plain = base_ok
    && issue.word[rjhb_pkg::EXT_HI:rjhb_pkg::EXT8_HI+1] == 2'h0
    && issue.word[rjhb_pkg::EXT8_HI:rjhb_pkg::EXT_LO] == rjhb_pkg::EXT_LINK_JUMP
    && link_reg_field == rjhb_pkg::REG_ZERO;
  assign any_jump = link_jump_reg_barrier || jump_reg_barrier
    || link_jump_reg || jump_reg_plain;
  assign is_barrier = link_jump_reg_barrier || jump_reg_barrier;
  assign is_link = link_jump_reg_barrier || link_jump_reg;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  rjhb_pkg::rjhb_state_t state;
  rjhb_pkg::rjhb_state_t next_state;
  logic barrier_q;        // current jump is a barrier
  logic start;            // accepted in idle
  logic [rjhb_pkg::XLEN-1:0] tgt;
  logic tgt_sel;
  logic tgt_err;

  assign start = state == rjhb_pkg::ST_IDLE && any_jump;

  // source sampled in the jump's own cycle, so the slot cannot alter it
  rjhb_target u_target (
    .clk_sys(clk_sys),
    .reset(reset),
    .load(start),
    .src(src_value),
    .compressed_isa_present(compressed_isa_present),
    .full_isa_present(full_isa_present),
    .tgt(tgt),
    .isa_sel(tgt_sel),
    .addr_err(tgt_err)
  );

  // next state
  always_comb begin
    next_state = state;
    case (state)
      rjhb_pkg::ST_IDLE: begin
        if (any_jump) begin
          next_state = rjhb_pkg::ST_SLOT;
        end
      end
      rjhb_pkg::ST_SLOT: begin
        // transfer waits for the delay slot to retire
        if (slot_done) begin
          next_state = barrier_q ? rjhb_pkg::ST_DRAIN : rjhb_pkg::ST_REDIR;
        end
      end
      rjhb_pkg::ST_DRAIN: begin
        // slot writes may still be pending; they are not waited for
        // beyond this drain, which is conservative but legal
        if (!ctrl_writes_pending) begin
          next_state = rjhb_pkg::ST_REDIR;
        end
      end
      rjhb_pkg::ST_REDIR: begin
        next_state = rjhb_pkg::ST_IDLE;
      end
      default: begin
        next_state = rjhb_pkg::ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state <= rjhb_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // barrier flavour of the jump in flight
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      barrier_q <= 1'h0;
    end else if (start) begin
      barrier_q <= is_barrier;
    end
  end

  // hazard snapshot: pending writes seen when a barrier jump issued; slot
  // writes are only covered by the drain if still pending then
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hazard_snapshot <= 1'h0;
    end else if (start) begin
      hazard_snapshot <= is_barrier && ctrl_writes_pending;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // link write registered in the jump's own cycle, strobe seen one cycle later
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      link_wb <= '0;
    end else begin
      link_wb.we <= start && is_link;
      link_wb.idx <= link_reg_field;
      link_wb.data <= issue.pc + rjhb_pkg::LINK_OFFSET;
    end
  end

  // redirect pulse and clear pulse
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      redirect <= '0;
      hazard_clear_action <= 1'h0;
    end else begin
      redirect.valid <= next_state == rjhb_pkg::ST_REDIR
        && state != rjhb_pkg::ST_REDIR;
      redirect.pc <= tgt;
      redirect.isa_sel <= tgt_sel;
      redirect.addr_err <= tgt_err;
      hazard_clear_action <= (next_state == rjhb_pkg::ST_REDIR
        && state != rjhb_pkg::ST_REDIR && barrier_q)
        || (exception_return_issue && cop_access_enabled);
    end
  end

  // busy: decode must stall further jumps
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      busy <= 1'h0;
    end else begin
      busy <= next_state != rjhb_pkg::ST_IDLE;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_link_value: assert property (@(posedge clk_sys) disable iff (reset)
    start && is_link |=> link_wb.we && link_wb.data == $past(issue.pc) + 64'h8)
    else $error("link value wrong");
  a_plain_nolink: assert property (@(posedge clk_sys) disable iff (reset)
    start && !is_link |=> !link_wb.we)
    else $error("link written by plain jump");
  a_slot_first: assert property (@(posedge clk_sys) disable iff (reset)
    redirect.valid |-> $past(slot_done) || $past(state) == rjhb_pkg::ST_DRAIN)
    else $error("redirect before slot");
  a_bit0_clear: assert property (@(posedge clk_sys) disable iff (reset)
    redirect.valid && compressed_isa_present |-> !redirect.pc[0])
    else $error("target bit 0 set");
  a_drain_hold: assert property (@(posedge clk_sys) disable iff (reset)
    state == rjhb_pkg::ST_DRAIN && ctrl_writes_pending |=> !redirect.valid)
    else $error("fetch released during drain");
  a_barrier_clear: assert property (@(posedge clk_sys) disable iff (reset)
    redirect.valid && $past(barrier_q) |-> hazard_clear_action)
    else $error("barrier without clear");
  a_exception_return_gate: assert property (@(posedge clk_sys) disable iff (reset)
    exception_return_issue && !cop_access_enabled && state == rjhb_pkg::ST_IDLE |=> !hazard_clear_action)
    else $error("return cleared without access");
  a_decode_start: assert property (@(posedge clk_sys) disable iff (reset)
    state == rjhb_pkg::ST_IDLE && is_barrier |=> state == rjhb_pkg::ST_SLOT)
    else $error("barrier form not accepted");
  a_fault_full: assert property (@(posedge clk_sys) disable iff (reset)
    start && full_isa_present && !src_value[0] && src_value[1] |=> tgt_err)
    else $error("fault missed");
  a_fault_short: assert property (@(posedge clk_sys) disable iff (reset)
    start && !full_isa_present && !src_value[0] |=> tgt_err)
    else $error("fault missed");

  c_barrier_link: cover property (@(posedge clk_sys) link_jump_reg_barrier && start);
  c_barrier_plain: cover property (@(posedge clk_sys) jump_reg_barrier && start);
  c_drain_wait: cover property (@(posedge clk_sys)
    state == rjhb_pkg::ST_DRAIN && ctrl_writes_pending);
  c_fault: cover property (@(posedge clk_sys) redirect.valid && redirect.addr_err);
endmodule : rjhb_unit
`default_nettype wire

// File: rjhb_pkg.sv
`default_nettype none
package rjhb_pkg;
  // ---------------------------------------------------------------
  // widths and instruction fields
  // ---------------------------------------------------------------
  localparam int unsigned XLEN = 64;            // general register width
  localparam logic [5:0] MAJOR_OPCODE_GROUP = 6'h00;  // bits 31..26
  localparam logic [5:0] EXTENDED_MINOR_GROUP = 6'h3c; // bits 5..0
  localparam logic [9:0] EXT_BARRIER_JUMP = 10'h07c;  // bits 15..6, barrier form
  localparam logic [7:0] EXT_LINK_JUMP = 8'h3c;       // bits 13..6, plain link form
  localparam int unsigned OP_HI = 31;
  localparam int unsigned OP_LO = 26;
  localparam int unsigned LINK_HI = 25;
  localparam int unsigned LINK_LO = 21;
  localparam int unsigned TGT_HI = 20;
  localparam int unsigned TGT_LO = 16;
  localparam int unsigned EXT_HI = 15;
  localparam int unsigned EXT_LO = 6;
  localparam int unsigned EXT8_HI = 13;
  localparam int unsigned MIN_HI = 5;
  localparam int unsigned MIN_LO = 0;
  localparam logic [XLEN-1:0] LINK_OFFSET = 64'h0000000000000008; // return addr = pc + 8
  localparam logic [4:0] REG_ZERO = 5'h00;
  localparam logic [XLEN-1:0] PC_RESET = 64'h0000000000000000;
  localparam logic [1:0] SLOT_WAIT_CYCLES = 2'h1;   // delay slot occupies one issue

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic valid;          // instruction presented by decode
    logic [31:0] word;    // raw instruction word
    logic [XLEN-1:0] pc;  // address of the jump
  } rjhb_issue_t;

  typedef struct packed {
    logic valid;          // one-cycle redirect to fetch
    logic [XLEN-1:0] pc;  // target address
    logic isa_sel;        // instruction set selector
    logic addr_err;       // fetch of target must fault
  } rjhb_redirect_t;

  typedef struct packed {
    logic we;             // one-cycle write strobe
    logic [4:0] idx;      // destination register
    logic [XLEN-1:0] data;// link value
  } rjhb_wb_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,       // waiting for a jump
    ST_SLOT = 4'h2,       // delay slot executing
    ST_DRAIN = 4'h4,      // barrier: waiting for control writes
    ST_REDIR = 4'h8       // redirect issued
  } rjhb_state_t;
endpackage : rjhb_pkg
`default_nettype wire

// File: rjhb_target.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------------------
// target former: registered target, selector and fault flag
// ---------------------------------------------------------------
module rjhb_target (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic load,
  input wire logic [rjhb_pkg::XLEN-1:0] src,
  input wire logic compressed_isa_present,
  input wire logic full_isa_present,
  output logic [rjhb_pkg::XLEN-1:0] tgt,
  output logic isa_sel,
  output logic addr_err
);
  logic [rjhb_pkg::XLEN-1:0] next_tgt; // formed target
  logic next_sel;                      // formed selector
  logic next_err;                      // formed fault

  // target formation, pure function of the source and the two set-present inputs
  always_comb begin
    if (compressed_isa_present) begin
      next_tgt = {src[rjhb_pkg::XLEN-1:1], 1'h0};
      next_sel = src[0];
    end else begin
      next_tgt = src;
      next_sel = 1'h0;
    end
    // fault is not raised here, only tagged for the target fetch
    if (full_isa_present) begin
      next_err = !src[0] && src[1];
    end else begin
      next_err = !src[0];
    end
  end

  // capture on load only; held otherwise
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tgt <= rjhb_pkg::PC_RESET;
      isa_sel <= 1'h0;
      addr_err <= 1'h0;
    end else if (load) begin
      tgt <= next_tgt;
      isa_sel <= next_sel;
      addr_err <= next_err;
    end
  end
endmodule : rjhb_target
`default_nettype wire

// File: register_jump_hazard_barrier_bench.sv
`timescale 1ns/1ps
`default_nettype none
module register_jump_hazard_barrier_bench;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic clk_sys; // 20 MHz core clock
  logic reset; // async, active high
  rjhb_pkg::rjhb_issue_t issue; // jump from decode
  logic [rjhb_pkg::XLEN-1:0] src_value; // register named by target field
  logic slot_done; // delay slot retired
  logic ctrl_writes_pending; // control writes still in flight
  logic exception_return_issue; // exception return pulse
  logic cop_access_enabled; // coprocessor access level
  logic compressed_isa_present; // compressed set configured
  logic full_isa_present; // full-width set configured
  logic busy;
  logic hazard_clear_action;
  logic hazard_snapshot;
  rjhb_pkg::rjhb_wb_t link_wb;
  rjhb_pkg::rjhb_redirect_t redirect;
  int n_mismatch; // mismatches seen
  int tests_run; // comparisons made

  rjhb_unit dut_u (
    .clk_sys(clk_sys),
    .reset(reset),
    .issue(issue),
    .src_value(src_value),
    .slot_done(slot_done),
    .ctrl_writes_pending(ctrl_writes_pending),
    .exception_return_issue(exception_return_issue),
    .cop_access_enabled(cop_access_enabled),
    .compressed_isa_present(compressed_isa_present),
    .full_isa_present(full_isa_present),
    .busy(busy),
    .link_wb(link_wb),
    .redirect(redirect),
    .hazard_clear_action(hazard_clear_action),
    .hazard_snapshot(hazard_snapshot)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // compare with case equality so an unknown never matches
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // builds a register jump word, barrier or plain extended code
  function automatic logic [31:0] mk(input logic [4:0] link, input logic [4:0] tgt,
                                     input logic bar);
    mk = {rjhb_pkg::MAJOR_OPCODE_GROUP, link, tgt,
          bar ? rjhb_pkg::EXT_BARRIER_JUMP : {2'h0, rjhb_pkg::EXT_LINK_JUMP},
          rjhb_pkg::EXTENDED_MINOR_GROUP};
  endfunction : mk

  // single place where the run ends
  task automatic test_done();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  // ---------------------------------------------------------------
  // one jump: issue, slot, optional drain, redirect
  // ---------------------------------------------------------------
  // dup presents a second jump while busy; it must leave no trace
  task automatic run_jump(input logic [31:0] word, input logic [63:0] pc,
                          input logic [63:0] src, input int pend, input logic dup,
                          input logic exp_link, input logic [4:0] exp_idx,
                          input logic [63:0] exp_pc, input logic exp_isa,
                          input logic chk_isa, input logic exp_err, input logic exp_hc);
    int n;
    @(negedge clk_sys);
    issue = '{valid: 1'h1, word: word, pc: pc};
    src_value = src;
    ctrl_writes_pending = (pend > 0);
    @(negedge clk_sys);
    issue.valid = dup;
    issue.pc = pc + 64'h100;
    src_value = ~src;
    chk("busy", busy, 1'h1);
    chk("link_we", link_wb.we, exp_link);
    if (exp_link) begin
      chk("link_idx", link_wb.idx, exp_idx);
      chk("link_data", link_wb.data, pc + 64'h8);
    end
    chk("snapshot", hazard_snapshot, exp_hc && pend > 0);
    // slot still running: no transfer and no second link write yet
    repeat (2) begin
      @(negedge clk_sys);
      issue.valid = 1'h0;
      chk("early_redirect", redirect.valid, 1'h0);
      chk("dup_link_we", link_wb.we, 1'h0);
    end
    slot_done = 1'h1;
    @(negedge clk_sys);
    slot_done = 1'h0;
    n = 0;
    // bounded wait; pending drops after pend cycles of drain
    while (redirect.valid !== 1'h1 && n < 12) begin
      if (n == pend) ctrl_writes_pending = 1'h0;
      chk("busy_wait", busy, 1'h1);
      @(negedge clk_sys);
      n++;
    end
    if (n == pend) ctrl_writes_pending = 1'h0;
    chk("redirect", redirect.valid, 1'h1);
    if (pend > 0) chk("drain_hold", n > pend, 1'h1);
    chk("target", redirect.pc, exp_pc);
    if (chk_isa) chk("isa_sel", redirect.isa_sel, exp_isa);
    chk("addr_err", redirect.addr_err, exp_err);
    chk("hazard_clear", hazard_clear_action, exp_hc);
    @(negedge clk_sys);
    chk("redirect_len", redirect.valid, 1'h0);
    repeat (3) begin
      @(negedge clk_sys);
      chk("idle_busy", busy, 1'h0);
      chk("extra_redirect", redirect.valid, 1'h0);
    end
  endtask : run_jump

  // exception return clears hazards only with coprocessor access
  task automatic run_exception_return(input logic en);
    int seen;
    seen = 0;
    @(negedge clk_sys);
    cop_access_enabled = en;
    exception_return_issue = 1'h1;
    @(negedge clk_sys);
    exception_return_issue = 1'h0;
    repeat (3) begin
      if (hazard_clear_action === 1'h1) seen++;
      @(negedge clk_sys);
    end
    chk("exception_return_clear", 64'(seen), 64'(en));
  endtask : run_exception_return

  // words outside the register jump forms must leave the unit idle
  task automatic run_nojump(input logic [31:0] word);
    @(negedge clk_sys);
    issue = '{valid: 1'h1, word: word, pc: 64'h6000};
    @(negedge clk_sys);
    issue.valid = 1'h0;
    chk("nojump_busy", busy, 1'h0);
    chk("nojump_link", link_wb.we, 1'h0);
    @(negedge clk_sys);
    chk("nojump_redirect", redirect.valid, 1'h0);
  endtask : run_nojump

  // ---------------------------------------------------------------
  // clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'h0;
    forever #25 clk_sys = ~clk_sys;
  end

  // whole run is well under 200 cycles; 4000 leaves room
  initial begin
    #200000;
    n_mismatch++;
    test_done();
  end

  initial begin
    n_mismatch = 0;
    tests_run = 0;
    reset = 1'h1;
    issue = '0;
    src_value = 64'h0;
    slot_done = 1'h0;
    ctrl_writes_pending = 1'h0;
    exception_return_issue = 1'h0;
    cop_access_enabled = 1'h0;
    compressed_isa_present = 1'h1;
    full_isa_present = 1'h1;
    repeat (4) @(negedge clk_sys);
    // outputs stay quiet while reset is held
    chk("reset_busy", busy, 1'h0);
    chk("reset_redirect", redirect.valid, 1'h0);
    chk("reset_link_we", link_wb.we, 1'h0);
    chk("reset_clear", hazard_clear_action, 1'h0);
    reset = 1'h0;
    // link barrier jump with access disabled, odd source, drain of 3
    run_jump(mk(5'h05, 5'h03, 1'h1), 64'h1000, 64'h402001, 3, 1'h0,
             1'h1, 5'h05, 64'h402000, 1'h1, 1'h1, 1'h0, 1'h1);
    // plain jump, bit 0 clear and bit 1 set faults; second jump refused
    run_jump(mk(5'h00, 5'h1f, 1'h0), 64'h2000, 64'h402, 0, 1'h1,
             1'h0, 5'h00, 64'h402, 1'h0, 1'h1, 1'h1, 1'h0);
    // barrier jump without compressed set keeps whole value
    compressed_isa_present = 1'h0;
    run_jump(mk(5'h00, 5'h04, 1'h1), 64'h3000, 64'hffff000012345678, 1, 1'h0,
             1'h0, 5'h00, 64'hffff000012345678, 1'h0, 1'h0, 1'h0, 1'h1);
    // no full-width set: even source faults, odd one does not
    compressed_isa_present = 1'h1;
    full_isa_present = 1'h0;
    run_jump(mk(5'h00, 5'h06, 1'h0), 64'h4000, 64'h8000, 0, 1'h0,
             1'h0, 5'h00, 64'h8000, 1'h0, 1'h1, 1'h1, 1'h0);
    run_jump(mk(5'h1f, 5'h07, 1'h0), 64'h5000, 64'h9003, 0, 1'h0,
             1'h1, 5'h1f, 64'h9002, 1'h1, 1'h1, 1'h0, 1'h0);
    // wrong minor group, wrong major group, wrong extended code
    run_nojump(mk(5'h05, 5'h03, 1'h1) ^ 32'h00000001);
    run_nojump(mk(5'h05, 5'h03, 1'h1) ^ 32'h04000000);
    run_nojump(mk(5'h05, 5'h03, 1'h0) ^ 32'h00004000);
    run_exception_return(1'h1);
    run_exception_return(1'h0);
    test_done();
  end
endmodule : register_jump_hazard_barrier_bench
`default_nettype wire
